// File: verilog/fac_regs.sv
// Purpose: Alert masking, high limits, fan drive setting and fan loop configuration.
// Assumes: AXI4-Lite slave, register at byte address four times its index.
// Notes:   Status inputs are levels from the measurement and fan logic.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module fac_regs
   import fac_pkg::*;
#(
   parameter int UNIT_CYCLES = UNIT_CYCLES_DEF
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  temp_local,
   input  wire logic [7:0]  temp_remote1,
   input  wire logic [7:0]  temp_remote2,
   input  wire logic [7:0]  temp_remote3,
   input  wire logic        fan_stall,
   input  wire logic        fan_spin_fail,
   input  wire logic        fan_drive_fail,
   input  wire logic        die_overheat_flag,
   input  wire logic [7:0]  loop_target,
   output logic             alert_n,
   output logic [7:0]       fan_drive,
   output logic             closed_loop_on,
   output logic [3:0]       tach_count_mult,
   output logic [3:0]       tach_edges,
   output logic [3:0]       high_status
);
   import fac_pkg::*;

   logic [7:0]  temp_en_reg;
   logic [7:0]  fan_en_reg;
   logic [7:0]  limit_reg [4];
   logic [7:0]  loop_cfg_reg;
   logic [7:0]  ctrl_reg;
   logic [5:0]  max_step_reg;
   logic [3:0]  high_reg;
   logic        alert_n_reg;
   logic [3:0]  mult_reg;
   logic [3:0]  edges_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [6:0]  aw_idx_reg;
   logic [7:0]  w_byte_reg;
   logic        w_lane0_reg;
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        do_write;
   logic        do_read;
   logic [6:0]  ar_idx;
   logic [7:0]  drive_reg;
   logic [7:0]  temp_in [4];
   logic [3:0]  over_limit;
   logic        wr_ok;

   // Channel order: 0 local, 1..3 remote diodes, matching enable bit order.
   assign temp_in[0] = temp_local;
   assign temp_in[1] = temp_remote1;
   assign temp_in[2] = temp_remote2;
   assign temp_in[3] = temp_remote3;

   // Returns one when the word index names a register of this bank.
   function automatic logic idx_mapped(input logic [6:0] idx);
      case (idx)
         IDX_TEMP_ALERT_EN, IDX_FAN_ALERT_EN, IDX_REMOTE1_LIM, IDX_REMOTE2_LIM,
         IDX_REMOTE3_LIM, IDX_LOCAL_LIM, IDX_DRIVE_SET, IDX_LOOP_CFG,
         IDX_CTRL, IDX_MAX_STEP, IDX_STATUS:
            idx_mapped = 1'b1;
         default:
            idx_mapped = 1'b0;
      endcase
   endfunction : idx_mapped

   // Limit slot for a limit index; slot 0 is the local channel.
   function automatic logic [1:0] limit_slot(input logic [6:0] idx);
      case (idx)
         IDX_REMOTE1_LIM: limit_slot = 2'h1;
         IDX_REMOTE2_LIM: limit_slot = 2'h2;
         IDX_REMOTE3_LIM: limit_slot = 2'h3;
         default:         limit_slot = 2'h0;
      endcase
   endfunction : limit_slot

   // Write address channel: one address held until its response is taken.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= 7'h00;
      end
      else if (s_axi_awvalid && awready_reg)
      begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b1;
         aw_idx_reg  <= s_axi_awaddr[8:2];
      end
      else if (do_write)
         aw_held_reg <= 1'b0;
      else if (!aw_held_reg && !bvalid_reg)
         awready_reg <= 1'b1;
   end

   // Write data channel, taken independently of the address.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wready_reg  <= 1'b0;
         w_held_reg  <= 1'b0;
         w_byte_reg  <= 8'h00;
         w_lane0_reg <= 1'b0;
      end
      else if (s_axi_wvalid && wready_reg)
      begin
         wready_reg  <= 1'b0;
         w_held_reg  <= 1'b1;
         w_byte_reg  <= s_axi_wdata[7:0];
         w_lane0_reg <= s_axi_wstrb[0];
      end
      else if (do_write)
         w_held_reg <= 1'b0;
      else if (!w_held_reg && !bvalid_reg)
         wready_reg <= 1'b1;
   end

   // A write is performed once both halves are held; registers only see
   // data when byte lane 0 is strobed, since every register is one byte wide.
   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_ok    = do_write && w_lane0_reg;

   // Write response.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= idx_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // Alert enable registers; unused bits never store.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         temp_en_reg <= RST_ALERT_EN;
         fan_en_reg  <= RST_ALERT_EN;
      end
      else
      begin
         if (wr_ok && aw_idx_reg == IDX_TEMP_ALERT_EN)
            temp_en_reg <= w_byte_reg & TEMP_EN_MASK;
         else if (!ctrl_reg[CTRL_DIODE3])
            temp_en_reg[REMOTE3_BIT] <= 1'b0;
         if (wr_ok && aw_idx_reg == IDX_TEMP_ALERT_EN && !ctrl_reg[CTRL_DIODE3])
            temp_en_reg[REMOTE3_BIT] <= 1'b0;
         if (wr_ok && aw_idx_reg == IDX_FAN_ALERT_EN)
            fan_en_reg <= w_byte_reg & FAN_EN_MASK;
      end
   end

   // High limits, refused once the lock is set.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 4; i++)
            limit_reg[i] <= RST_LIMIT;
      end
      else if (wr_ok && !ctrl_reg[CTRL_LOCK_BIT] &&
               (aw_idx_reg == IDX_REMOTE1_LIM || aw_idx_reg == IDX_REMOTE2_LIM ||
                aw_idx_reg == IDX_REMOTE3_LIM || aw_idx_reg == IDX_LOCAL_LIM))
         limit_reg[limit_slot(aw_idx_reg)] <= w_byte_reg;
   end

   // Loop configuration, control (lock is sticky until reset) and max step.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loop_cfg_reg <= RST_LOOP_CFG;
         ctrl_reg     <= RST_CTRL;
         max_step_reg <= RST_MAX_STEP;
      end
      else if (wr_ok)
      begin
         if (aw_idx_reg == IDX_LOOP_CFG)
            loop_cfg_reg <= w_byte_reg;
         if (aw_idx_reg == IDX_CTRL)
         begin
            ctrl_reg[CTRL_DIODE3]   <= w_byte_reg[CTRL_DIODE3];
            ctrl_reg[CTRL_LOCK_BIT] <= ctrl_reg[CTRL_LOCK_BIT] | w_byte_reg[CTRL_LOCK_BIT];
         end
         if (aw_idx_reg == IDX_MAX_STEP)
            max_step_reg <= w_byte_reg[5:0];
      end
   end

   // Signed comparison of each channel against its limit.
   generate
      for (genvar c = 0; c < 4; c++)
      begin : g_cmp
         assign over_limit[c] = $signed(temp_in[c]) >= $signed(limit_reg[c]);
      end
   endgenerate

   // High status is sticky; a status read clears bits whose condition has
   // gone, and a live condition always wins over the clear.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         high_reg <= 4'h0;
      else if (do_read && ar_idx == IDX_STATUS)
         high_reg <= over_limit;
      else
         high_reg <= high_reg | over_limit;
   end

   // Alert is recomputed every cycle; overheat never takes part.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         alert_n_reg <= 1'b1;
      else
         alert_n_reg <= ~(|(high_reg & temp_en_reg[3:0])
                          | (fan_spin_fail & fan_en_reg[SPIN_EN_BIT])
                          | ((fan_stall | fan_drive_fail) & fan_en_reg[STALL_EN_BIT]));
   end

   // Decoded tach settings for the measurement logic.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mult_reg  <= fac_range_mult(RST_LOOP_CFG[RANGE_LSB +: 2]);
         edges_reg <= fac_edge_count(RST_LOOP_CFG[EDGES_LSB +: 2]);
      end
      else
      begin
         mult_reg  <= fac_range_mult(loop_cfg_reg[RANGE_LSB +: 2]);
         edges_reg <= fac_edge_count(loop_cfg_reg[EDGES_LSB +: 2]);
      end
   end

   // Applied drive; manual writes pass only while the loop is off.
   fac_ramp #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_ramp (
      .clk            (clk),
      .rst            (rst),
      .closed_loop_on (loop_cfg_reg[LOOP_ON_BIT]),
      .loop_target    (loop_target),
      .update_code    (loop_cfg_reg[UPDATE_LSB +: 3]),
      .max_step       (max_step_reg),
      .man_wr         (wr_ok && aw_idx_reg == IDX_DRIVE_SET),
      .man_data       (w_byte_reg),
      .drive_reg      (drive_reg)
   );

   // Read address channel; one read in flight.
   assign ar_idx  = s_axi_araddr[8:2];
   assign do_read = s_axi_arvalid && arready_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         arready_reg <= 1'b0;
      else if (do_read)
         arready_reg <= 1'b0;
      else if (!rvalid_reg)
         arready_reg <= 1'b1;
   end

   // Read data; the drive setting shows the applied drive, not the last write.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0;
         rresp_reg  <= RESP_OKAY;
      end
      else if (do_read)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
         case (ar_idx)
            IDX_TEMP_ALERT_EN: rdata_reg <= {24'h0, temp_en_reg};
            IDX_FAN_ALERT_EN:  rdata_reg <= {24'h0, fan_en_reg};
            IDX_REMOTE1_LIM,
            IDX_REMOTE2_LIM,
            IDX_REMOTE3_LIM,
            IDX_LOCAL_LIM:     rdata_reg <= {24'h0, limit_reg[limit_slot(ar_idx)]};
            IDX_DRIVE_SET:     rdata_reg <= {24'h0, drive_reg};
            IDX_LOOP_CFG:      rdata_reg <= {24'h0, loop_cfg_reg};
            IDX_CTRL:          rdata_reg <= {24'h0, 6'h00, ctrl_reg[1:0]};
            IDX_MAX_STEP:      rdata_reg <= {24'h0, 2'h0, max_step_reg};
            IDX_STATUS:        rdata_reg <= {24'h0, die_overheat_flag, fan_drive_fail,
                                             fan_spin_fail, fan_stall, high_reg};
            default:           rdata_reg <= 32'h0;
         endcase
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // Outputs straight from flip-flops. The drive code goes to a linear driver
   // whose output is code/255 of the fan supply.
   assign s_axi_awready   = awready_reg;
   assign s_axi_wready    = wready_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_arready   = arready_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
   assign alert_n         = alert_n_reg;
   assign fan_drive       = drive_reg;
   assign closed_loop_on  = loop_cfg_reg[LOOP_ON_BIT];
   assign tach_count_mult = mult_reg;
   assign tach_edges      = edges_reg;
   assign high_status     = high_reg;

endmodule : fac_regs

// File: verilog/fac_pkg.sv
// Purpose: Shared constants for the fan alert and configuration register bank.
// Assumes: 50 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   Register indices are word indices; the byte address is four times the index.
package fac_pkg;

   // Register word indices.
   localparam logic [6:0] IDX_TEMP_ALERT_EN = 7'h28;
   localparam logic [6:0] IDX_FAN_ALERT_EN  = 7'h29;
   localparam logic [6:0] IDX_REMOTE1_LIM   = 7'h30;
   localparam logic [6:0] IDX_REMOTE2_LIM   = 7'h31;
   localparam logic [6:0] IDX_REMOTE3_LIM   = 7'h32;
   localparam logic [6:0] IDX_LOCAL_LIM     = 7'h34;
   localparam logic [6:0] IDX_DRIVE_SET     = 7'h40;
   localparam logic [6:0] IDX_LOOP_CFG      = 7'h42;
   localparam logic [6:0] IDX_CTRL          = 7'h50;
   localparam logic [6:0] IDX_MAX_STEP      = 7'h51;
   localparam logic [6:0] IDX_STATUS        = 7'h52;

   // Reset values.
   localparam logic [7:0] RST_ALERT_EN = 8'h00;
   localparam logic [7:0] RST_LIMIT    = 8'h55;
   localparam logic [7:0] RST_DRIVE    = 8'h00;
   localparam logic [7:0] RST_LOOP_CFG = 8'h2B;
   localparam logic [7:0] RST_CTRL     = 8'h00;
   localparam logic [5:0] RST_MAX_STEP = 6'h10;

   // Field positions.
   localparam int LOOP_ON_BIT   = 7;
   localparam int RANGE_LSB     = 5;
   localparam int EDGES_LSB     = 3;
   localparam int UPDATE_LSB    = 0;
   localparam int CTRL_LOCK_BIT = 0;
   localparam int CTRL_DIODE3   = 1;
   localparam int REMOTE3_BIT   = 3;
   localparam int SPIN_EN_BIT   = 1;
   localparam int STALL_EN_BIT  = 0;

   // Valid bit masks of the enable registers.
   localparam logic [7:0] TEMP_EN_MASK = 8'h0F;
   localparam logic [7:0] FAN_EN_MASK  = 8'h03;

   // Update interval base unit and its cycle count at the clock rate.
   localparam int UPDATE_UNIT_MS  = 100;
   localparam int CLK_KHZ         = 50000;
   localparam int UNIT_CYCLES_DEF = UPDATE_UNIT_MS * CLK_KHZ;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Tach count multiplier for a range code.
   function automatic logic [3:0] fac_range_mult(input logic [1:0] code);
      fac_range_mult = 4'h1 << code;
   endfunction : fac_range_mult

   // Tach edges per rotation for an edges code.
   function automatic logic [3:0] fac_edge_count(input logic [1:0] code);
      fac_edge_count = 4'h3 + {1'b0, code, 1'b0};
   endfunction : fac_edge_count

   // Update interval in base units for an update code.
   function automatic logic [4:0] fac_update_units(input logic [2:0] code);
      case (code)
         3'h5:    fac_update_units = 5'h08;
         3'h6:    fac_update_units = 5'h0C;
         3'h7:    fac_update_units = 5'h10;
         default: fac_update_units = {2'h0, code} + 5'h01;
      endcase
   endfunction : fac_update_units

endpackage : fac_pkg

// File: verilog/fac_ramp.sv
// Purpose: Applied fan drive with update-interval timing and step-limited ramping.
// Assumes: Closed-loop target comes from the speed loop; manual writes are pre-qualified.
// Notes:   The unit count is a parameter so simulation can shorten the 100 ms base.
`timescale 1ns/1ns
module fac_ramp
   import fac_pkg::*;
#(
   parameter int UNIT_CYCLES = UNIT_CYCLES_DEF
)
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       closed_loop_on,
   input  wire logic [7:0] loop_target,
   input  wire logic [2:0] update_code,
   input  wire logic [5:0] max_step,
   input  wire logic       man_wr,
   input  wire logic [7:0] man_data,
   output logic      [7:0] drive_reg
);
   logic [31:0] unit_cnt_reg;
   logic [4:0]  unit_num_reg;
   logic        tick;
   logic [7:0]  diff;
   logic [7:0]  step;

   generate
      if (UNIT_CYCLES < 2)
      begin : g_bad_units
         $error("UNIT_CYCLES must be at least 2");
      end
   endgenerate

   // Base unit and interval counters; a tick closes each update interval.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         unit_cnt_reg <= 32'h0;
         unit_num_reg <= 5'h00;
      end
      else if (unit_cnt_reg == 32'(UNIT_CYCLES - 1))
      begin
         unit_cnt_reg <= 32'h0;
         unit_num_reg <= tick ? 5'h00 : unit_num_reg + 5'h01;
      end
      else
      begin
         unit_cnt_reg <= unit_cnt_reg + 32'h1;
      end
   end

   assign tick = (unit_cnt_reg == 32'(UNIT_CYCLES - 1)) &&
                 (unit_num_reg + 5'h01 >= fac_update_units(update_code));

   // Step is the smaller of the remaining distance and the max step.
   always_comb
   begin
      diff = (loop_target > drive_reg) ? loop_target - drive_reg : drive_reg - loop_target;
      step = (diff > {2'h0, max_step}) ? {2'h0, max_step} : diff;
   end

   // Closed loop ramps once per interval; manual writes land at once and the
   // last value is kept when the loop is switched off.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         drive_reg <= RST_DRIVE;
      else if (closed_loop_on)
      begin
         if (tick)
            drive_reg <= (loop_target > drive_reg) ? drive_reg + step : drive_reg - step;
      end
      else if (man_wr)
         drive_reg <= man_data;
   end

endmodule : fac_ramp

// File: sim/fac_regs_assertions.sv
// Purpose: Bus timing, alert and drive checks on the register bank ports.
// Assumes: One clock domain with asynchronous active-high reset.
// Notes:   Bound to every fac_regs instance below.
`timescale 1ns/1ns
module fac_regs_chk
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       fan_stall,
   input wire logic       fan_spin_fail,
   input wire logic       fan_drive_fail,
   input wire logic       alert_n,
   input wire logic [7:0] fan_drive,
   input wire logic       closed_loop_on,
   input wire logic [3:0] tach_count_mult,
   input wire logic [3:0] tach_edges,
   input wire logic [3:0] high_status
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Handshakes; reads are exempt from the sticky check since a status read may clear.
   wire w_hs  = s_axi_wvalid && s_axi_wready;
   wire rd_hs = s_axi_arvalid && s_axi_arready;
   wire quiet = (high_status == 4'h0) && !fan_stall && !fan_spin_fail && !fan_drive_fail;
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && w_hs;
   endsequence
   sequence wr_resp;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_read_answer:
      assert property (rd_hs |=> s_axi_rvalid) else $error("read answer late");
   a_write_answer:
      assert property (wr_both |=> wr_resp) else $error("write answer mistimed");
   a_read_done:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
   a_ready_back:
      assert property (s_axi_bvalid && s_axi_bready |=> ##[0:1] (s_axi_awready && s_axi_wready))
         else $error("write readies not back");
   a_drive_manual:
      assert property (!closed_loop_on && !$past(closed_loop_on) && !$past(closed_loop_on, 2)
         && !$past(w_hs) && !$past(w_hs, 2) |-> $stable(fan_drive)) else $error("drive moved");
   a_high_sticky:
      assert property (!$past(rd_hs) && !$past(rd_hs, 2)
         |-> (high_status & $past(high_status)) == $past(high_status)) else $error("high lost");
   a_alert_release:
      assert property (quiet |=> alert_n) else $error("alert held without cause");
   a_tach_codes:
      assert property (tach_count_mult inside {4'h1, 4'h2, 4'h4, 4'h8}
         && tach_edges inside {4'h3, 4'h5, 4'h7, 4'h9}) else $error("tach decode illegal");
endmodule : fac_regs_chk

bind fac_regs fac_regs_chk u_chk (.clk, .rst, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_awvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .fan_stall, .fan_spin_fail, .fan_drive_fail, .alert_n,
   .fan_drive, .closed_loop_on, .tach_count_mult, .tach_edges, .high_status);

// File: sim/fac_fan_model.sv
// Purpose: Fan driver and tachometer side facing the register bank.
// Assumes: Faults and the speed goal are commanded by the bench.
// Notes:   Reports levels one cycle late, as a tach monitor would.
`timescale 1ns/1ns
module fac_fan_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] fault_cmd,
   input  wire logic [7:0] speed_goal,
   output logic            fan_stall,
   output logic            fan_spin_fail,
   output logic            fan_drive_fail,
   output logic      [7:0] loop_target
);
   // Registered so no fault can reach the bank inside the edge that commands it.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {fan_drive_fail, fan_spin_fail, fan_stall} <= 3'h0;
         loop_target <= 8'h00;
      end
      else
      begin
         {fan_drive_fail, fan_spin_fail, fan_stall} <= fault_cmd;
         loop_target <= speed_goal;
      end
   end
endmodule : fac_fan_model

// File: sim/fan_alert_config_regs_test.sv
// Purpose: Register, alert and drive tests through the AXI4-Lite port.
// Assumes: Update unit shortened to 10 clocks.
// Notes:   Expected values come from the register table and rule figures.
`timescale 1ns/1ns
module fan_alert_config_regs_test;
   import fac_pkg::*;
   logic        clk = 1'h0, rst = 1'h1, s_axi_rvalid, s_axi_bvalid, alert_n, closed_loop_on;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, die_overheat_flag = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_arready, fan_stall, fan_spin_fail;
   logic        fan_drive_fail;
   logic [3:0]  s_axi_wstrb = 4'hF, tach_count_mult, tach_edges, high_status;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  temps [4] = '{4{8'h00}}, speed_goal = 8'h00, loop_target, fan_drive;
   logic [2:0]  fault_cmd = 3'h0;
   logic [6:0]  lims [4] = '{IDX_REMOTE1_LIM, IDX_REMOTE2_LIM, IDX_REMOTE3_LIM, IDX_LOCAL_LIM};
   int          n_fail = 0, n_tests = 0, n;

   fac_regs #(.UNIT_CYCLES(10)) uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .temp_local(temps[0]), .temp_remote1(temps[1]),
      .temp_remote2(temps[2]), .temp_remote3(temps[3]), .fan_stall, .fan_spin_fail,
      .fan_drive_fail, .die_overheat_flag, .loop_target, .alert_n, .fan_drive, .closed_loop_on,
      .tach_count_mult, .tach_edges, .high_status);
   fac_fan_model fan (.clk, .rst, .fault_cmd, .speed_goal, .fan_stall, .fan_spin_fail,
      .fan_drive_fail, .loop_target);

   // Free-running 50 MHz clock.
   initial forever #10 clk = ~clk;

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmp

   // Address and data go out together; each is dropped as soon as it is taken.
   task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      logic aw, w;
      aw = 1'h0;
      w = 1'h0;
      s_axi_awaddr <= {23'h0, idx, 2'h0};
      s_axi_wdata <= {24'hA5A5A5, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(aw && w))
      begin
         @(posedge clk);
         if (!aw && s_axi_awready === 1'h1)
         begin
            aw = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w && s_axi_wready === 1'h1)
         begin
            w = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      cmp("bresp", er, s_axi_bresp);
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [6:0] idx, input logic [31:0] exp,
      input logic [1:0] er = RESP_OKAY);
      s_axi_araddr <= {23'h0, idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      cmp("rdata", exp, s_axi_rdata);
      cmp("rresp", er, s_axi_rresp);
      @(posedge clk);
   endtask : rd

   // Waits, bounded, for the applied drive to move, counting the cycles taken.
   task automatic step(input logic [7:0] exp, output int c);
      logic [7:0] was;
      was = exp - 8'h10;
      c = 0;
      while (fan_drive === was && c < 200)
      begin
         @(posedge clk);
         c++;
      end
      cmp("fan_drive", exp, fan_drive);
   endtask : step

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   // Main sequence.
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rd(IDX_TEMP_ALERT_EN, 32'h0);
      rd(IDX_FAN_ALERT_EN, 32'h0);
      foreach (lims[i]) rd(lims[i], 32'h55);
      rd(IDX_DRIVE_SET, 32'h0);
      rd(IDX_LOOP_CFG, 32'h2B);
      rd(7'h7F, 32'h0, RESP_SLVERR);
      wr(7'h7F, 8'h12, RESP_SLVERR);
      $display("test reset_values done");
      wr(IDX_TEMP_ALERT_EN, 8'hFF);
      rd(IDX_TEMP_ALERT_EN, 32'h07);
      wr(IDX_CTRL, 8'h02);
      wr(IDX_TEMP_ALERT_EN, 8'h0F);
      rd(IDX_TEMP_ALERT_EN, 32'h0F);
      wr(IDX_FAN_ALERT_EN, 8'hFF);
      rd(IDX_FAN_ALERT_EN, 32'h03);
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_TEMP_ALERT_EN, 8'h0F ^ (8'h01 << i));
         temps[i] <= 8'h55;
         repeat (3) @(posedge clk);
         cmp("high_status", 32'h1 << i, high_status);
         cmp("alert_n masked", 32'h1, alert_n);
         wr(IDX_TEMP_ALERT_EN, 8'h01 << i);
         repeat (3) @(posedge clk);
         cmp("alert_n", 32'h0, alert_n);
         temps[i] <= 8'h80;
         rd(IDX_STATUS, 32'h1 << i);
         repeat (3) @(posedge clk);
         cmp("alert_n released", 32'h1, alert_n);
      end
      die_overheat_flag <= 1'h1;
      repeat (3) @(posedge clk);
      cmp("alert_n overheat", 32'h1, alert_n);
      die_overheat_flag <= 1'h0;
      $display("test temp_alerts done");
      for (int j = 0; j < 3; j++)
      begin
         wr(IDX_FAN_ALERT_EN, (j == 1) ? 8'h01 : 8'h02);
         fault_cmd <= 3'h1 << j;
         repeat (3) @(posedge clk);
         cmp("alert_n fan masked", 32'h1, alert_n);
         rd(IDX_STATUS, 32'h10 << j);
         wr(IDX_FAN_ALERT_EN, 8'h03);
         repeat (3) @(posedge clk);
         cmp("alert_n fan", 32'h0, alert_n);
         fault_cmd <= 3'h0;
         repeat (3) @(posedge clk);
         cmp("alert_n fan clear", 32'h1, alert_n);
      end
      $display("test fan_alerts done");
      wr(IDX_LOCAL_LIM, 8'hE0);
      temps[0] <= 8'hE1;
      repeat (3) @(posedge clk);
      cmp("high_status signed", 32'h1, high_status);
      wr(IDX_CTRL, 8'h03);
      foreach (lims[i]) wr(lims[i], 8'h11);
      foreach (lims[i]) rd(lims[i], (i == 3) ? 32'hE0 : 32'h55);
      $display("test limits_lock done");
      for (int k = 0; k < 4; k++)
      begin
         wr(IDX_LOOP_CFG, {1'h0, k[1:0], k[1:0], 3'h0});
         cmp("tach_count_mult", 32'h1 << k, tach_count_mult);
         cmp("tach_edges", 3 + 2 * k, tach_edges);
      end
      wr(IDX_DRIVE_SET, 8'h40);
      cmp("fan_drive manual", 32'h40, fan_drive);
      speed_goal <= 8'h70;
      wr(IDX_MAX_STEP, 8'h10);
      wr(IDX_LOOP_CFG, 8'hA9);
      cmp("closed_loop_on", 32'h1, closed_loop_on);
      step(8'h50, n);
      step(8'h60, n);
      cmp("update interval", 32'd20, n);
      step(8'h70, n);
      wr(IDX_DRIVE_SET, 8'h00);
      rd(IDX_DRIVE_SET, 32'h70);
      wr(IDX_LOOP_CFG, 8'h29);
      speed_goal <= 8'h10;
      repeat (30) @(posedge clk);
      cmp("fan_drive held", 32'h70, fan_drive);
      wr(IDX_DRIVE_SET, 8'hC8);
      cmp("fan_drive written", 32'hC8, fan_drive);
      $display("test drive_loop done");
      complete_run();
   end

   // Watchdog sized well above the roughly 400 cycles the tests need.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run();
   end
endmodule : fan_alert_config_regs_test
